// >>> transfer_pkg.sv
// Shared constants and enumerations for the data-transfer execution block.
// Assumes the core supplies one operation request at a time while the block is idle.
package transfer_pkg;

    localparam int          DATA_W       = 8;
    localparam int          ADDR_W       = 8;
    localparam int          IO_ADDR_W    = 6;
    localparam int          TIMER_W      = 16;
    localparam logic [7:0]  BIT_ADDR_MAX = 8'h3F;
    localparam logic [7:0]  WORK_RESET   = 8'h00;
    localparam logic [15:0] SNAP_RESET   = 16'h0000;
    localparam logic [7:0]  ADDR_STEP    = 8'h01;

    // Operation codes presented on opCode together with opStart.
    typedef enum logic [3:0] {
        OP_LOAD_IMM             = 4'h0,
        OP_STORE_MEM            = 4'h1,
        OP_LOAD_MEM             = 4'h2,
        OP_LOAD_IO              = 4'h3,
        OP_STORE_IO             = 4'h4,
        OP_TIMER_READ_TO_RAM    = 4'h5,
        OP_TIMER_WRITE_FROM_RAM = 4'h6,
        OP_ADD_MEM              = 4'h7,
        OP_SUB_MEM              = 4'h8,
        OP_BIT_SET              = 4'h9,
        OP_BIT_CLEAR            = 4'hA
    } op_t;

    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_MEMDATA = 6'h02,
        ST_IODATA  = 6'h04,
        ST_WRHI    = 6'h08,
        ST_TLO     = 6'h10,
        ST_THI     = 6'h20
    } state_t;

endpackage : transfer_pkg

// >>> flag_calc.sv
// Eight-bit add or subtract with the four arithmetic status flags.
// Purely combinational; the caller registers whatever it keeps.
module flag_calc
    import transfer_pkg::*;
(
    input  wire logic [7:0] opA,
    input  wire logic [7:0] opB,
    input  wire logic       subtract,
    output logic      [7:0] result,
    output logic            zero,
    output logic            carry,
    output logic            halfCarry,
    output logic            overflow
);

    logic [8:0] wide;
    logic [4:0] lowWide;

    always_comb begin
        if (subtract) begin
            wide    = {1'b0, opA} - {1'b0, opB};
            lowWide = {1'b0, opA[3:0]} - {1'b0, opB[3:0]};
        end else begin
            wide    = {1'b0, opA} + {1'b0, opB};
            lowWide = {1'b0, opA[3:0]} + {1'b0, opB[3:0]};
        end
        result    = wide[7:0];
        zero      = (wide[7:0] == 8'h00);
        // Bit 8 of the wide sum is carry out on add and borrow on subtract.
        carry     = wide[8];
        halfCarry = lowWide[4];
        if (subtract) begin
            overflow = (opA[7] != opB[7]) && (wide[7] != opA[7]);
        end else begin
            overflow = (opA[7] == opB[7]) && (wide[7] != opA[7]);
        end
    end

endmodule : flag_calc

// >>> data_transfer_instructions.sv
// Execution of the core's data-transfer operations plus the shared status flags.
// Assumes an asynchronous-read data memory and IO space: read data is valid in
// the same cycle as the registered read enable. The counter is sampled as given.
// Behaviour
// - Immediate load sets working register, flags kept.
// - Memory store writes working register, flags kept.
// - Memory load sets working register and zero.
// - IO load sets working register and zero.
// - IO store writes working register, flags kept.
// - Counter read stores 16-bit count, flags kept.
// - Counter write loads 16-bit word, flags kept.
// - Bit operations only on addresses 0 to 0x3F.
// - Zero result sets zero flag.
// - Carry flags unsigned carry or borrow.
// - Half carry flags low-nibble carry or borrow.
// - Overflow flags signed two's-complement range error.
module data_transfer_instructions
    import transfer_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    input  wire logic                 opStart,
    input  wire logic [3:0]           opCode,
    input  wire logic [DATA_W-1:0]    immData,
    input  wire logic [ADDR_W-1:0]    memAddr,
    input  wire logic [2:0]           bitSel,
    input  wire logic [IO_ADDR_W-1:0] ioAddr,
    input  wire logic [DATA_W-1:0]    memRdData,
    input  wire logic [DATA_W-1:0]    ioRdData,
    input  wire logic [TIMER_W-1:0]   counterValue,
    output logic                      busy,
    output logic                      opDone,
    output logic                      bitAddrError,
    output logic [DATA_W-1:0]         workingRegister,
    output logic                      zeroFlag,
    output logic                      carryFlag,
    output logic                      nibbleHalfBit,
    output logic                      signedRangeError,
    output logic                      memRdEn,
    output logic                      memWrEn,
    output logic [ADDR_W-1:0]         memAddrOut,
    output logic [DATA_W-1:0]         memWrData,
    output logic                      ioRdEn,
    output logic                      ioWrEn,
    output logic [IO_ADDR_W-1:0]      ioAddrOut,
    output logic [DATA_W-1:0]         ioWrData,
    output logic                      counterLoad,
    output logic [TIMER_W-1:0]        counterLoadValue
);
    logic rstMeta_reg, rstSync_reg;
    // The release is synchronised so that no state leaves reset on a partial edge.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_reg <= 1'b0;
            rstSync_reg <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstSync_reg <= rstMeta_reg;
        end
    end
    state_t               state_reg,   state_next;
    op_t                  op_reg,      op_next;
    logic [2:0]           bit_reg,     bit_next;
    logic [TIMER_W-1:0]   snap_reg,    snap_next;
    logic [DATA_W-1:0]    work_reg,    work_next;
    logic                 zf_reg,      zf_next;
    logic                 cf_reg,      cf_next;
    logic                 hf_reg,      hf_next;
    logic                 of_reg,      of_next;
    logic                 busy_reg,    busy_next;
    logic                 done_reg,    done_next;
    logic                 berr_reg,    berr_next;
    logic                 mrd_reg,     mrd_next;
    logic                 mwr_reg,     mwr_next;
    logic [ADDR_W-1:0]    maddr_reg,   maddr_next;
    logic [DATA_W-1:0]    mdata_reg,   mdata_next;
    logic                 iord_reg,    iord_next;
    logic                 iowr_reg,    iowr_next;
    logic [IO_ADDR_W-1:0] ioaddr_reg,  ioaddr_next;
    logic [DATA_W-1:0]    iodata_reg,  iodata_next;
    logic                 cload_reg,   cload_next;
    logic [TIMER_W-1:0]   cvalue_reg,  cvalue_next;
    logic [DATA_W-1:0]    aluResult;
    logic                 aluZero,     aluCarry,    aluHalf,     aluOver;
    flag_calc flag_calc_i (.opA(work_reg), .opB(memRdData), .subtract(op_reg == OP_SUB_MEM),
        .result(aluResult), .zero(aluZero), .carry(aluCarry), .halfCarry(aluHalf),
        .overflow(aluOver));
    function automatic logic [DATA_W-1:0] bitMask(input logic [2:0] n);
        bitMask = 8'h01 << n;
    endfunction : bitMask
    always_comb begin
        state_next  = state_reg;
        op_next     = op_reg;
        bit_next    = bit_reg;
        snap_next   = snap_reg;
        work_next   = work_reg;
        zf_next     = zf_reg;
        cf_next     = cf_reg;
        hf_next     = hf_reg;
        of_next     = of_reg;
        busy_next   = busy_reg;
        done_next   = 1'b0;
        berr_next   = 1'b0;
        mrd_next    = 1'b0;
        mwr_next    = 1'b0;
        maddr_next  = maddr_reg;
        mdata_next  = mdata_reg;
        iord_next   = 1'b0;
        iowr_next   = 1'b0;
        ioaddr_next = ioaddr_reg;
        iodata_next = iodata_reg;
        cload_next  = 1'b0;
        cvalue_next = cvalue_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (opStart) begin
                    op_next    = op_t'(opCode);
                    bit_next   = bitSel;
                    maddr_next = memAddr;
                    busy_next  = 1'b1;
                    unique case (opCode)
                        OP_LOAD_IMM: begin
                            work_next = immData;
                            busy_next = 1'b0;
                            done_next = 1'b1;
                        end
                        OP_STORE_MEM: begin
                            mwr_next   = 1'b1;
                            mdata_next = work_reg;
                            busy_next  = 1'b0;
                            done_next  = 1'b1;
                        end
                        OP_LOAD_MEM, OP_ADD_MEM, OP_SUB_MEM: begin
                            mrd_next   = 1'b1;
                            state_next = ST_MEMDATA;
                        end
                        OP_LOAD_IO: begin
                            iord_next   = 1'b1;
                            ioaddr_next = ioAddr;
                            state_next  = ST_IODATA;
                        end
                        OP_STORE_IO: begin
                            iowr_next   = 1'b1;
                            ioaddr_next = ioAddr;
                            iodata_next = work_reg;
                            busy_next   = 1'b0;
                            done_next   = 1'b1;
                        end
                        OP_TIMER_READ_TO_RAM: begin
                            // The whole count is frozen here so the high byte
                            // written next cycle belongs to the same sample.
                            snap_next  = counterValue;
                            mwr_next   = 1'b1;
                            mdata_next = counterValue[7:0];
                            state_next = ST_WRHI;
                        end
                        OP_TIMER_WRITE_FROM_RAM: begin
                            mrd_next   = 1'b1;
                            state_next = ST_TLO;
                        end
                        OP_BIT_SET, OP_BIT_CLEAR: begin
                            if (memAddr > BIT_ADDR_MAX) begin
                                berr_next = 1'b1;
                                busy_next = 1'b0;
                                done_next = 1'b1;
                            end else begin
                                mrd_next   = 1'b1;
                                state_next = ST_MEMDATA;
                            end
                        end
                        default: begin
                            // Unknown codes complete at once; only the latched address and operands change.
                            busy_next = 1'b0;
                            done_next = 1'b1;
                        end
                    endcase
                end
            end
            ST_MEMDATA: begin
                if (op_reg == OP_LOAD_MEM) begin
                    work_next = memRdData;
                    zf_next  = (memRdData == 8'h00);
                end else if (op_reg == OP_ADD_MEM || op_reg == OP_SUB_MEM) begin
                    work_next = aluResult;
                    zf_next  = aluZero;
                    cf_next  = aluCarry;
                    hf_next  = aluHalf;
                    of_next  = aluOver;
                end else if (op_reg == OP_BIT_SET) begin
                    mwr_next   = 1'b1;
                    mdata_next = memRdData | bitMask(bit_reg);
                end else begin
                    mwr_next   = 1'b1;
                    mdata_next = memRdData & ~bitMask(bit_reg);
                end
                busy_next  = 1'b0;
                done_next  = 1'b1;
                state_next = ST_IDLE;
            end
            ST_IODATA: begin
                work_next  = ioRdData;
                zf_next    = (ioRdData == 8'h00);
                busy_next  = 1'b0;
                done_next  = 1'b1;
                state_next = ST_IDLE;
            end
            ST_WRHI: begin
                mwr_next   = 1'b1;
                maddr_next = maddr_reg + ADDR_STEP;
                mdata_next = snap_reg[15:8];
                busy_next  = 1'b0;
                done_next  = 1'b1;
                state_next = ST_IDLE;
            end
            ST_TLO: begin
                snap_next  = {8'h00, memRdData};
                mrd_next   = 1'b1;
                maddr_next = maddr_reg + ADDR_STEP;
                state_next = ST_THI;
            end
            ST_THI: begin
                // One load of all sixteen bits, never a byte at a time.
                cload_next  = 1'b1;
                cvalue_next = {memRdData, snap_reg[7:0]};
                busy_next   = 1'b0;
                done_next   = 1'b1;
                state_next  = ST_IDLE;
            end
        endcase
    end
    always_ff @(posedge clk_sys or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            state_reg  <= ST_IDLE;
            op_reg     <= OP_LOAD_IMM;
            bit_reg    <= 3'h0;
            snap_reg   <= SNAP_RESET;
            work_reg   <= WORK_RESET;
            zf_reg     <= 1'b0;
            cf_reg     <= 1'b0;
            hf_reg     <= 1'b0;
            of_reg     <= 1'b0;
            busy_reg   <= 1'b0;
            done_reg   <= 1'b0;
            berr_reg   <= 1'b0;
            mrd_reg    <= 1'b0;
            mwr_reg    <= 1'b0;
            maddr_reg  <= 8'h00;
            mdata_reg  <= 8'h00;
            iord_reg   <= 1'b0;
            iowr_reg   <= 1'b0;
            ioaddr_reg <= 6'h00;
            iodata_reg <= 8'h00;
            cload_reg  <= 1'b0;
            cvalue_reg <= SNAP_RESET;
        end else begin
            state_reg  <= state_next;
            op_reg     <= op_next;
            bit_reg    <= bit_next;
            snap_reg   <= snap_next;
            work_reg   <= work_next;
            zf_reg     <= zf_next;
            cf_reg     <= cf_next;
            hf_reg     <= hf_next;
            of_reg     <= of_next;
            busy_reg   <= busy_next;
            done_reg   <= done_next;
            berr_reg   <= berr_next;
            mrd_reg    <= mrd_next;
            mwr_reg    <= mwr_next;
            maddr_reg  <= maddr_next;
            mdata_reg  <= mdata_next;
            iord_reg   <= iord_next;
            iowr_reg   <= iowr_next;
            ioaddr_reg <= ioaddr_next;
            iodata_reg <= iodata_next;
            cload_reg  <= cload_next;
            cvalue_reg <= cvalue_next;
        end
    end
    assign busy             = busy_reg;
    assign opDone           = done_reg;
    assign bitAddrError     = berr_reg;
    assign workingRegister  = work_reg;
    assign zeroFlag         = zf_reg;
    assign carryFlag        = cf_reg;
    assign nibbleHalfBit    = hf_reg;
    assign signedRangeError = of_reg;
    assign memRdEn          = mrd_reg;
    assign memWrEn          = mwr_reg;
    assign memAddrOut       = maddr_reg;
    assign memWrData        = mdata_reg;
    assign ioRdEn           = iord_reg;
    assign ioWrEn           = iowr_reg;
    assign ioAddrOut        = ioaddr_reg;
    assign ioWrData         = iodata_reg;
    assign counterLoad      = cload_reg;
    assign counterLoadValue = cvalue_reg;
endmodule : data_transfer_instructions

// >>> data_transfer_instructions_chk.sv
// Concurrent checks on the data-transfer block, seen from its top-level ports.
// Assumes the bind below; ops are only requested once the internal reset is released.
module data_transfer_instructions_chk
    import transfer_pkg::*;
(
    input wire logic                 clk_sys,
    input wire logic                 reset_n,
    input wire logic                 opStart,
    input wire logic [3:0]           opCode,
    input wire logic [DATA_W-1:0]    immData,
    input wire logic [ADDR_W-1:0]    memAddr,
    input wire logic [IO_ADDR_W-1:0] ioAddr,
    input wire logic [DATA_W-1:0]    memRdData,
    input wire logic [DATA_W-1:0]    ioRdData,
    input wire logic [TIMER_W-1:0]   counterValue,
    input wire logic                 busy,
    input wire logic                 opDone,
    input wire logic                 bitAddrError,
    input wire logic [DATA_W-1:0]    workingRegister,
    input wire logic                 zeroFlag,
    input wire logic                 carryFlag,
    input wire logic                 nibbleHalfBit,
    input wire logic                 signedRangeError,
    input wire logic                 memRdEn,
    input wire logic                 memWrEn,
    input wire logic [ADDR_W-1:0]    memAddrOut,
    input wire logic [DATA_W-1:0]    memWrData,
    input wire logic                 ioRdEn,
    input wire logic                 ioWrEn,
    input wire logic [IO_ADDR_W-1:0] ioAddrOut,
    input wire logic [DATA_W-1:0]    ioWrData,
    input wire logic                 counterLoad,
    input wire logic [TIMER_W-1:0]   counterLoadValue
);
    logic       go;
    logic       workTop;
    logic       rdTop;
    logic [3:0] flags;
    logic [2:0] arith;
    assign go     = opStart && !busy;
    assign workTop = workingRegister[7];
    assign rdTop  = memRdData[7];
    assign flags  = {zeroFlag, carryFlag, nibbleHalfBit, signedRangeError};
    assign arith  = {carryFlag, nibbleHalfBit, signedRangeError};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    property p_imm;
        go && opCode == OP_LOAD_IMM |=> opDone && workingRegister == $past(immData) && $stable(flags);
    endproperty
    a_imm: assert property (p_imm) else $error("immediate load wrong");
    property p_stm;
        go && opCode == OP_STORE_MEM |=> memWrEn && memAddrOut == $past(memAddr)
            && memWrData == $past(workingRegister) && $stable(flags);
    endproperty
    a_stm: assert property (p_stm) else $error("memory store wrong");
    property p_ldm;
        go && opCode == OP_LOAD_MEM |=> memRdEn && memAddrOut == $past(memAddr) ##1 opDone
            && workingRegister == $past(memRdData) && zeroFlag == ($past(memRdData) == 8'h00)
            && $stable(arith);
    endproperty
    a_ldm: assert property (p_ldm) else $error("memory load wrong");
    property p_ldio;
        go && opCode == OP_LOAD_IO |=> ioRdEn && ioAddrOut == $past(ioAddr) ##1 opDone
            && workingRegister == $past(ioRdData) && zeroFlag == ($past(ioRdData) == 8'h00)
            && $stable(arith);
    endproperty
    a_ldio: assert property (p_ldio) else $error("io load wrong");
    property p_stio;
        go && opCode == OP_STORE_IO |=> ioWrEn && ioAddrOut == $past(ioAddr)
            && ioWrData == $past(workingRegister) && $stable(flags);
    endproperty
    a_stio: assert property (p_stio) else $error("io store wrong");
    property p_trd;
        go && opCode == OP_TIMER_READ_TO_RAM |=> memWrEn && memWrData == 8'($past(counterValue))
            ##1 memWrEn && opDone && memWrData == 8'($past(counterValue, 2) >> 8)
            && memAddrOut == $past(memAddr, 2) + ADDR_STEP && $stable(flags);
    endproperty
    a_trd: assert property (p_trd) else $error("counter read wrong");
    property p_twr;
        go && opCode == OP_TIMER_WRITE_FROM_RAM |=> memRdEn ##1 memRdEn ##1 counterLoad
            && opDone
            && counterLoadValue == {$past(memRdData), $past(memRdData, 2)} && $stable(flags);
    endproperty
    a_twr: assert property (p_twr) else $error("counter write wrong");
    property p_bit;
        go && (opCode == OP_BIT_SET || opCode == OP_BIT_CLEAR) && memAddr > BIT_ADDR_MAX
            |=> bitAddrError && opDone && !memRdEn && !memWrEn && $stable(flags);
    endproperty
    a_bit: assert property (p_bit) else $error("bit op range wrong");
    property p_add;
        go && opCode == OP_ADD_MEM |=> ##1 opDone
            && workingRegister == 8'($past(workingRegister) + $past(memRdData))
            && zeroFlag == (workingRegister == 8'h00)
            && carryFlag == (9'($past(workingRegister)) + 9'($past(memRdData)) > 9'h0FF)
            && nibbleHalfBit == (5'($past(workingRegister) & 8'h0F)
                + 5'($past(memRdData) & 8'h0F) > 5'h0F)
            && signedRangeError == ($past(workTop) == $past(rdTop)
                && workTop != $past(workTop));
    endproperty
    a_add: assert property (p_add) else $error("add flags wrong");
    c_twr: cover property (go && opCode == OP_TIMER_WRITE_FROM_RAM);
    c_err: cover property (bitAddrError);
    c_refused: cover property (opStart && busy);
endmodule : data_transfer_instructions_chk

bind data_transfer_instructions data_transfer_instructions_chk data_transfer_instructions_chk_i (
    .clk_sys, .reset_n, .opStart, .opCode, .immData, .memAddr, .ioAddr, .memRdData,
    .ioRdData, .counterValue, .busy, .opDone, .bitAddrError, .workingRegister, .zeroFlag,
    .carryFlag, .nibbleHalfBit, .signedRangeError, .memRdEn, .memWrEn, .memAddrOut,
    .memWrData, .ioRdEn, .ioWrEn, .ioAddrOut, .ioWrData, .counterLoad, .counterLoadValue);

// >>> data_transfer_instructions_tb.sv
// Self-checking bench for the data-transfer block against an integer reference model.
// The bench plays memory, IO space and counter itself; inputs change on falling edges.
module data_transfer_instructions_tb import transfer_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        opStart = 1'b0;
    logic [3:0]  opCode = 4'h0;
    logic [7:0]  immData = 8'h00;
    logic [7:0]  memAddr = 8'h00;
    logic [2:0]  bitSel = 3'h0;
    logic [5:0]  ioAddr = 6'h00;
    logic [7:0]  noise = 8'h00;
    logic [15:0] counterValue = 16'h0000;
    logic [7:0]  memRdData, ioRdData, workingRegister, memAddrOut, memWrData, ioWrData, ew;
    logic        busy, opDone, bitAddrError, zeroFlag, carryFlag, nibbleHalfBit, signedRangeError;
    logic        memRdEn, memWrEn, ioRdEn, ioWrEn, counterLoad;
    logic [5:0]  ioAddrOut;
    logic [15:0] counterLoadValue;
    logic [7:0]  ram [256];
    logic [7:0]  em [256];
    logic [7:0]  ioSpace [64];
    logic [7:0]  eio [64];
    logic [3:0]  fl = 4'h0;
    logic [19:0] plan [23] = '{20'h00F20, 20'h40F01, 20'h30001, 20'h10020, 20'h00000, 20'h10021,
        20'h20021, 20'h20020, 20'h00122, 20'h10022, 20'h07F00, 20'h70022, 20'h0FF00, 20'h70022,
        20'h80022, 20'h08000, 20'h80022, 20'h500FF, 20'h600FF, 20'h9003F, 20'hA0040, 20'h900FF,
        20'hB0010};
    int          seed = 59793;
    int          num_errors = 0;
    int          compares = 0;
    int          cycles = 0;
    data_transfer_instructions data_transfer_instructions_i (.clk_sys, .reset_n, .opStart,
        .opCode, .immData, .memAddr, .bitSel, .ioAddr, .memRdData, .ioRdData, .counterValue,
        .busy, .opDone, .bitAddrError, .workingRegister, .zeroFlag, .carryFlag, .nibbleHalfBit,
        .signedRangeError, .memRdEn, .memWrEn, .memAddrOut, .memWrData, .ioRdEn, .ioWrEn,
        .ioAddrOut, .ioWrData, .counterLoad, .counterLoadValue);
    // Unselected read lines carry noise so stale data can never pass for a real read.
    assign memRdData = memRdEn ? ram[memAddrOut] : noise;
    assign ioRdData  = ioRdEn ? ioSpace[ioAddrOut] : ~noise;
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (memWrEn) ram[memAddrOut] <= memWrData;
        if (ioWrEn) ioSpace[ioAddrOut] <= ioWrData;
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            $display("unexpected run length: expected under 5000 cycles, seen 5000");
            final_report();
        end
    end
    always @(negedge clk_sys) begin
        noise <= 8'($random(seed));
        counterValue <= counterLoad ? counterLoadValue : counterValue + 16'h0001;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task automatic final_report();
        $display("compares %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    // Entered at a falling edge; with keep set the request stays up for a back-to-back op.
    task automatic do_op(input logic [3:0] code, input logic [7:0] imm, input logic [7:0] addr,
                         input logic [2:0] bsel, input logic [5:0] ia, input bit keep,
                         input bit spam);
        int n;
        int a;
        int b;
        int r;
        logic [15:0] snap;
        logic [3:0] seen;
        logic bad;
        opCode = code;
        immData = imm;
        memAddr = addr;
        bitSel = bsel;
        ioAddr = ia;
        opStart = 1'b1;
        @(posedge clk_sys);
        snap = counterValue;
        n = 0;
        // The taking edge still shows the previous op's opDone, so only falling edges count.
        do begin
            @(negedge clk_sys);
            n++;
            if (opDone !== 1'b1) begin
                opStart = spam;
                opCode = 4'h0;
                immData = 8'($random(seed));
            end else if (!keep) begin
                opStart = 1'b0;
            end
        end while (opDone !== 1'b1 && n < 8);
        bad = (code == 4'h9 || code == 4'hA) && addr > BIT_ADDR_MAX;
        a = ew;
        b = em[addr];
        case (code)
            4'h0: ew = imm;
            4'h1: em[addr] = ew;
            4'h2, 4'h3: begin
                ew = (code == 4'h2) ? em[addr] : eio[ia];
                fl[3] = (ew == 8'h00);
            end
            4'h4: eio[ia] = ew;
            4'h5: begin
                em[addr] = snap[7:0];
                em[8'(addr + ADDR_STEP)] = snap[15:8];
            end
            4'h6: chk("counterLoadValue", {em[8'(addr + ADDR_STEP)], em[addr]}, counterLoadValue);
            4'h7, 4'h8: begin
                r = (code == 4'h7) ? a + b : a - b;
                ew = 8'(r);
                fl[3] = (ew == 8'h00);
                fl[2] = (code == 4'h7) ? (r > 255) : (a < b);
                fl[1] = (code == 4'h7) ? (a % 16 + b % 16 > 15) : (a % 16 < b % 16);
                fl[0] = ((a > 127) != ew[7]) && ((code == 4'h7) == ((a > 127) == (b > 127)));
            end
            4'h9, 4'hA: if (!bad) em[addr][bsel] = (code == 4'h9);
            default: ;
        endcase
        seen = {zeroFlag, carryFlag, nibbleHalfBit, signedRangeError};
        chk("latency", 16'((code == 4'h6) ? 3 : ((code inside {[4'h2:4'h3], 4'h5, [4'h7:4'hA]}
            && !bad) ? 2 : 1)), 16'(n));
        chk("workingRegister", {8'h00, ew}, {8'h00, workingRegister});
        chk("flags", {12'h000, fl}, {12'h000, seen});
        chk("bitAddrError", {15'h0, bad}, {15'h0, bitAddrError});
        chk("busy", 16'h0000, {15'h0, busy});
    endtask : do_op
    task automatic mem_check(input string name);
        opStart = 1'b0;
        repeat (2) @(negedge clk_sys);
        for (int i = 0; i < 256; i++) begin
            chk("ram", {8'h00, em[i]}, {8'h00, ram[i]});
        end
        for (int i = 0; i < 64; i++) begin
            chk("ioSpace", {8'h00, eio[i]}, {8'h00, ioSpace[i]});
        end
        $display("test %s ended, mismatches %0d", name, num_errors);
    endtask : mem_check
    initial begin
        for (int i = 0; i < 256; i++) begin
            ram[i] = 8'($random(seed));
            em[i] = ram[i];
            eio[i % 64] = ram[i];
            ioSpace[i % 64] = ram[i];
        end
        repeat (12) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        // Busy requests are thrown during every third directed op, when that op is multi-cycle; they must change nothing.
        for (int i = 0; i < 23; i++) begin
            do_op(plan[i][19:16], plan[i][15:8], plan[i][7:0], 3'h7, plan[i][5:0], 1'b1, i % 3 == 0);
        end
        mem_check("directed");
        for (int i = 0; i < 300; i++) begin
            do_op(4'($unsigned($random(seed)) % 12), 8'($random(seed)), 8'($random(seed)),
                  3'($random(seed)), 6'($random(seed)), 1'b1, 1'($random(seed)));
        end
        mem_check("random");
        final_report();
    end
endmodule : data_transfer_instructions_tb
